// >>> verilog/blvm_regs.svh
// Register offsets, field positions and reset values of the drawing control block
`ifndef BLVM_REGS_SVH
`define BLVM_REGS_SVH

// Byte offsets within the chip register window
`define BLVM_RASTER_OFS   16'h8200
`define BLVM_VECTOR_OFS   16'h8204
`define BLVM_BLIT_OFS     16'h8208
`define BLVM_STATUS_OFS   16'h820C

// Reset values
`define BLVM_REG_RST      32'h0000_0000

// Writable bits of each register
`define BLVM_RASTER_WMASK 32'h0000_03FF
`define BLVM_VECTOR_WMASK 32'h0000_000F
`define BLVM_BLIT_WMASK   32'h0000_01DF
`define BLVM_STATUS_WMASK 32'h0000_0300

// Raster control fields
`define BLVM_PAT_HI       9
`define BLVM_PAT_LO       8
`define BLVM_ROP_HI       7
`define BLVM_ROP_LO       0

// Vector control fields
`define BLVM_VEC_DST      3
`define BLVM_VEC_MIN      2
`define BLVM_VEC_MAJ      1
`define BLVM_VEC_VERTICAL_MAJOR     0

// Blit control fields
`define BLVM_BLT_YREV     8
`define BLVM_SFMT_HI      7
`define BLVM_SFMT_LO      6
`define BLVM_DSEL_HI      4
`define BLVM_DSEL_LO      2
`define BLVM_SSEL_HI      1
`define BLVM_SSEL_LO      0

// Status fields
`define BLVM_ST_WIDE      9
`define BLVM_ST_BPP16     8
`define BLVM_ST_PEND      2
`define BLVM_ST_PIPE      1
`define BLVM_ST_BUSY      0

// Line widths in bytes
`define BLVM_LINE_NARROW  12'h400
`define BLVM_LINE_WIDE    12'h800

`endif

// >>> verilog/blvm_pkg.sv
// Types shared by the drawing control block
package blvm_pkg;

  // Pattern format
  typedef enum logic [1:0] {
    PM_SOLID = 2'b00, PM_MONO = 2'b01, PM_DITHER = 2'b10, PM_COLOR = 2'b11
  } blvm_pat_t;

  // Source format
  typedef enum logic [1:0] {
    SF_COLOR = 2'b00, SF_MONO = 2'b01, SF_UNUSED = 2'b10, SF_GLYPH = 2'b11
  } blvm_sfmt_t;

  // Where operand data comes from
  typedef enum logic [1:0] {
    DK_NONE = 2'b00, DK_BUF = 2'b01, DK_FB = 2'b10
  } blvm_kind_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PIPE = 2'b01, ST_DRAIN = 2'b10
  } blvm_state_t;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } blvm_wb_req_t;

  // Decoded parameters of the running operation
  typedef struct packed {
    logic       is_blit;
    logic [7:0] raster_op_code;
    blvm_pat_t  pat;
    logic [3:0] pat_color_en;
    logic       pat_from_data;
    logic       fetch_fb_dst;
    logic       minor_pos;
    logic       major_pos;
    logic       y_major;
    logic       y_reverse;
    blvm_sfmt_t sfmt;
    logic       color_expand;
    logic       glyph_x_adv;
    blvm_kind_t dst_kind;
    logic       dst_ones;
    logic       dst_buf;
    blvm_kind_t src_kind;
    logic       src_ones;
    logic       src_buf;
  } blvm_op_t;

endpackage

// >>> verilog/blvm_ctrl.sv
// Control and status register bank of the 2D drawing pipeline
`timescale 1ns/100ps
`include "blvm_regs.svh"

module blvm_ctrl
  import blvm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire blvm_wb_req_t wb_i,
  output logic              wb_ack_o,
  output logic [31:0]       wb_dat_o,
  // Drawing engine handshake
  input  wire logic         pipe_done_i,
  input  wire logic         mem_done_i,
  output logic              start_o,
  output blvm_op_t          op_o,
  // Frame format and status
  output logic [11:0]       line_bytes_o,
  output logic              bpp16_o,
  output logic              pipe_busy_o,
  output logic              blit_busy_o,
  output logic              pending_o
);

  // Master parameter registers
  logic [31:0] raster_q;   // Pattern format and op code
  logic [31:0] vector_q;   // Vector direction flags
  logic [31:0] blit_q;     // Blit source and destination
  logic [31:0] status_q;   // Writable status bits only

  // Bus slave state
  logic        ack_q;      // One-cycle acknowledge
  logic [31:0] rdat_q;     // Registered read data
  logic        wr_hit;     // Write taken this edge
  logic        rd_hit;     // Read answered this edge
  logic        launch;     // A launching write

  // Sequencer state
  blvm_state_t state_q;
  blvm_state_t state_d;
  logic        pend_q;     // Operation waiting in master regs
  logic        pend_blit_q;// Waiting operation is a blit
  logic        xfer;       // Move master into working regs
  logic        start_q;    // Start pulse to engine
  blvm_op_t    op_q;       // Working parameters

  // Byte-lane merge of a write under its mask
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel,
                                        input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old_v & ~(lane & wmask)) | (new_v & lane & wmask);
  endfunction

  // Turn master registers into working parameters
  function automatic blvm_op_t decode(input logic [31:0] r,
                                      input logic [31:0] v,
                                      input logic [31:0] b,
                                      input logic        blit);
    blvm_op_t o;
    logic [2:0] dsel;
    logic [1:0] ssel;
    o = '0;
    dsel = b[`BLVM_DSEL_HI:`BLVM_DSEL_LO];
    ssel = b[`BLVM_SSEL_HI:`BLVM_SSEL_LO];
    o.is_blit = blit;
    o.raster_op_code = r[`BLVM_ROP_HI:`BLVM_ROP_LO];
    o.pat = blvm_pat_t'(r[`BLVM_PAT_HI:`BLVM_PAT_LO]);
    unique case (o.pat)
      PM_SOLID:  o.pat_color_en = 4'h1;
      PM_MONO:   o.pat_color_en = 4'h3;
      PM_DITHER: o.pat_color_en = 4'hF;
      PM_COLOR:  o.pat_from_data = 1'b1;
    endcase
    // Vector flags, then the blit reverse Y flag
    o.fetch_fb_dst = v[`BLVM_VEC_DST];
    o.minor_pos = v[`BLVM_VEC_MIN];
    o.major_pos = v[`BLVM_VEC_MAJ];
    o.y_major = v[`BLVM_VEC_VERTICAL_MAJOR];
    o.y_reverse = b[`BLVM_BLT_YREV];
    // Source format; the unused code expands nothing
    o.sfmt = blvm_sfmt_t'(b[`BLVM_SFMT_HI:`BLVM_SFMT_LO]);
    o.color_expand = (o.sfmt == SF_MONO) || (o.sfmt == SF_GLYPH);
    o.glyph_x_adv = (o.sfmt == SF_GLYPH);
    // Destination; undefined codes behave as no destination
    unique case (dsel)
      3'b010: begin
        o.dst_kind = DK_BUF;
      end
      3'b011: begin
        o.dst_kind = DK_BUF;
        o.dst_buf = 1'b1;
      end
      3'b100: begin
        o.dst_kind = DK_FB;
      end
      3'b101: begin
        o.dst_kind = DK_FB;
        o.dst_buf = 1'b1;
      end
      default: begin
        o.dst_kind = DK_NONE;
        o.dst_ones = 1'b1;
      end
    endcase
    // Source; frame source is staged in buffer 0
    unique case (ssel)
      2'b00: begin
        o.src_kind = DK_NONE;
        o.src_ones = 1'b1;
      end
      2'b01: o.src_kind = DK_FB;
      2'b10: o.src_kind = DK_BUF;
      2'b11: begin
        o.src_kind = DK_BUF;
        o.src_buf = 1'b1;
      end
    endcase
    decode = o;
  endfunction

  // Bus strobes; write lands at the edge the master sees ack
  assign wr_hit = wb_i.cyc & wb_i.stb & wb_i.we & ack_q;
  assign rd_hit = wb_i.cyc & wb_i.stb & ~wb_i.we & ~ack_q;
  assign launch = wr_hit & ((wb_i.adr == `BLVM_RASTER_OFS) |
                            (wb_i.adr == `BLVM_BLIT_OFS));

  // Acknowledge one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_i.cyc & wb_i.stb & ~ack_q;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= `BLVM_REG_RST;
    end else if (rd_hit) begin
      unique case (wb_i.adr)
        `BLVM_RASTER_OFS: rdat_q <= raster_q;
        `BLVM_VECTOR_OFS: rdat_q <= vector_q;
        `BLVM_BLIT_OFS:   rdat_q <= blit_q;
        `BLVM_STATUS_OFS: begin
          rdat_q <= status_q;
          rdat_q[`BLVM_ST_PEND] <= pend_q;
          rdat_q[`BLVM_ST_PIPE] <= (state_q == ST_PIPE);
          rdat_q[`BLVM_ST_BUSY] <= (state_q != ST_IDLE);
        end
        default: rdat_q <= `BLVM_REG_RST;
      endcase
    end
  end

  // Master registers; a load while pending overwrites it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raster_q <= `BLVM_REG_RST;
      vector_q <= `BLVM_REG_RST;
      blit_q   <= `BLVM_REG_RST;
      status_q <= `BLVM_REG_RST;
    end else if (wr_hit) begin
      if (wb_i.adr == `BLVM_RASTER_OFS) begin
        raster_q <= merge(raster_q, wb_i.dat, wb_i.sel, `BLVM_RASTER_WMASK);
      end
      if (wb_i.adr == `BLVM_VECTOR_OFS) begin
        vector_q <= merge(vector_q, wb_i.dat, wb_i.sel, `BLVM_VECTOR_WMASK);
      end
      if (wb_i.adr == `BLVM_BLIT_OFS) begin
        blit_q <= merge(blit_q, wb_i.dat, wb_i.sel, `BLVM_BLIT_WMASK);
      end
      if (wb_i.adr == `BLVM_STATUS_OFS) begin
        status_q <= merge(status_q, wb_i.dat, wb_i.sel, `BLVM_STATUS_WMASK);
      end
    end
  end

  // Transfer only when the engine is free
  assign xfer = pend_q & (state_q == ST_IDLE);

  // Pending flag; a new launch wins over the transfer clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q      <= 1'b0;
      pend_blit_q <= 1'b0;
    end else begin
      pend_q <= (pend_q & ~xfer) | launch;
      if (launch) begin
        pend_blit_q <= (wb_i.adr == `BLVM_BLIT_OFS);
      end
    end
  end

  // Sequencer: pipeline work, then memory drain
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (xfer) state_d = ST_PIPE;
      ST_PIPE:  if (pipe_done_i) state_d = ST_DRAIN;
      ST_DRAIN: if (mem_done_i) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // State and busy outputs, registered together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      pipe_busy_o <= 1'b0;
      blit_busy_o <= 1'b0;
    end else begin
      state_q     <= state_d;
      pipe_busy_o <= (state_d == ST_PIPE);
      blit_busy_o <= (state_d != ST_IDLE);
    end
  end

  // Working parameters latch at transfer, stable while running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q    <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= xfer;
      if (xfer) begin
        op_q <= decode(raster_q, vector_q, blit_q, pend_blit_q);
      end
    end
  end

  // Frame format follows the status bits, registered one edge later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_bytes_o <= `BLVM_LINE_NARROW;
      bpp16_o      <= 1'b0;
    end else begin
      line_bytes_o <= status_q[`BLVM_ST_WIDE] ? `BLVM_LINE_WIDE
                                             : `BLVM_LINE_NARROW;
      bpp16_o <= status_q[`BLVM_ST_BPP16];
    end
  end

  // Output wiring from flops
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;
  assign start_o   = start_q;
  assign op_o      = op_q;
  assign pending_o = pend_q;

  // Checks; one clock domain, so a default clock and disable serve all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A launching write, seen at the edge its ack is sampled
  sequence s_launch;
    launch;
  endsequence

  // Engine found idle, so pending work can move across
  sequence s_idle_next;
    (state_q == ST_IDLE);
  endsequence

  // Master parameters move into the working registers
  sequence s_xfer;
    xfer;
  endsequence

  // Status read that the slave answers on this edge
  sequence s_status_rd;
    rd_hit && (wb_i.adr == `BLVM_STATUS_OFS);
  endsequence

  // Launch, pending and start; a start is one cycle whatever the engine does
  a_launch_pend: assert property (s_launch |=> pend_q)
    else $error("launch did not set pending");
  a_launch_start: assert property (s_launch ##1 s_idle_next |=> start_q)
    else $error("idle engine did not start");
  a_xfer_busy: assert property (s_xfer |=> start_q && pipe_busy_o && blit_busy_o)
    else $error("transfer did not raise busy and start");
  a_start_pulse: assert property (start_q |=> !start_q)
    else $error("start held longer than one cycle");
  a_pend_clear: assert property (s_xfer && !launch |=> !pend_q)
    else $error("pending not cleared by transfer");
  a_pend_hold: assert property (pend_q && state_q == ST_PIPE |=> pend_q)
    else $error("pending dropped while running");

  // Pattern format decode, checked against the raster word that was moved
  a_solid_pat: assert property (start_q && $past(raster_q[`BLVM_PAT_HI:`BLVM_PAT_LO]) == PM_SOLID
    |-> op_q.pat_color_en == 4'h1)
    else $error("solid pattern color select wrong");
  a_mono_pat: assert property (start_q && $past(raster_q[`BLVM_PAT_HI:`BLVM_PAT_LO]) == PM_MONO
    |-> op_q.pat_color_en == 4'h3)
    else $error("mono pattern color select wrong");
  a_dither_pat: assert property (start_q && $past(raster_q[`BLVM_PAT_HI:`BLVM_PAT_LO]) == PM_DITHER
    |-> op_q.pat_color_en == 4'hF)
    else $error("dither pattern color select wrong");
  a_color_pat: assert property (start_q && $past(raster_q[`BLVM_PAT_HI:`BLVM_PAT_LO]) == PM_COLOR
    |-> op_q.pat_from_data)
    else $error("color pattern not from data");

  // Raster code and vector flags
  a_rop_code: assert property (start_q |-> op_q.raster_op_code == $past(raster_q[`BLVM_ROP_HI:`BLVM_ROP_LO]))
    else $error("raster op code not transferred");
  a_dst_fetch: assert property (start_q |-> op_q.fetch_fb_dst == $past(vector_q[`BLVM_VEC_DST]))
    else $error("destination fetch flag wrong");
  a_vec_dirs: assert property (start_q |-> {op_q.minor_pos, op_q.major_pos, op_q.y_major}
    == $past(vector_q[`BLVM_VEC_MIN:`BLVM_VEC_VERTICAL_MAJOR]))
    else $error("vector direction flags wrong");

  // Blit operand decode
  a_y_reverse: assert property (start_q |-> op_q.y_reverse == $past(blit_q[`BLVM_BLT_YREV]))
    else $error("reverse Y flag wrong");
  a_dst_ones: assert property (start_q && $past(blit_q[`BLVM_DSEL_HI:`BLVM_DSEL_LO]) == 3'b000
    |-> op_q.dst_ones && op_q.dst_kind == DK_NONE)
    else $error("no-destination did not feed ones");
  a_src_ones: assert property (start_q && $past(blit_q[`BLVM_SSEL_HI:`BLVM_SSEL_LO]) == 2'b00
    |-> op_q.src_ones && op_q.src_kind == DK_NONE)
    else $error("no-source did not feed ones");
  a_glyph_adv: assert property (start_q && $past(blit_q[`BLVM_SFMT_HI:`BLVM_SFMT_LO]) == SF_GLYPH
    |-> op_q.glyph_x_adv && op_q.color_expand)
    else $error("glyph source did not advance X");
  a_src_frame: assert property (start_q && $past(blit_q[`BLVM_SSEL_HI:`BLVM_SSEL_LO]) == 2'b01
    |-> op_q.src_kind == DK_FB && !op_q.src_ones)
    else $error("frame source not selected");
  a_dst_frame: assert property (start_q && $past(blit_q[`BLVM_DSEL_HI:`BLVM_DSEL_LO]) == 3'b100
    |-> op_q.dst_kind == DK_FB && !op_q.dst_buf)
    else $error("frame destination not staged in buffer 0");
  a_dst_buf1: assert property (start_q && $past(blit_q[`BLVM_DSEL_HI:`BLVM_DSEL_LO]) == 3'b011
    |-> op_q.dst_kind == DK_BUF && op_q.dst_buf)
    else $error("destination buffer 1 not selected");

  // Status read bits against the live flags of the request edge
  a_status_pend: assert property (s_status_rd
    |=> wb_dat_o[`BLVM_ST_PEND] == $past(pend_q))
    else $error("status pending bit wrong");
  a_status_pipe: assert property (s_status_rd
    |=> wb_dat_o[`BLVM_ST_PIPE] == $past(pipe_busy_o))
    else $error("status pipe busy bit wrong");
  a_status_busy: assert property (s_status_rd
    |=> wb_dat_o[`BLVM_ST_BUSY] == $past(blit_busy_o))
    else $error("status blit busy bit wrong");

  // Busy levels; blit busy outlives pipe busy by the memory drain
  a_busy_nest: assert property (pipe_busy_o |-> blit_busy_o)
    else $error("pipe busy without blit busy");
  a_pipe_end: assert property (state_q == ST_PIPE && pipe_done_i
    |=> !pipe_busy_o && blit_busy_o)
    else $error("pipe busy did not end on done");
  a_drain_end: assert property (state_q == ST_DRAIN && mem_done_i
    |=> !blit_busy_o)
    else $error("blit busy did not end on drain");

  // Frame format outputs trail the status bits by one edge
  a_wide_line: assert property (status_q[`BLVM_ST_WIDE] |=> line_bytes_o == `BLVM_LINE_WIDE)
    else $error("wide line width not applied");
  a_bpp_mode: assert property (bpp16_o == $past(status_q[`BLVM_ST_BPP16]))
    else $error("pixel depth output wrong");

endmodule // blvm_ctrl

// >>> tb/test_blit_vector_mode_control.sv
// Self-checking bench for the drawing control register bank
`timescale 1ns/100ps
`include "blvm_regs.svh"
module test_blit_vector_mode_control import blvm_pkg::*; ;

  // Bench-driven inputs
  logic         clk_i       = 1'b0;
  logic         rst_i       = 1'b1;
  blvm_wb_req_t wb_i        = '0;
  logic         pipe_done_i = 1'b0;
  logic         mem_done_i  = 1'b0;
  // Design outputs
  logic         wb_ack_o;
  logic [31:0]  wb_dat_o;
  logic         start_o;
  blvm_op_t     op_o;
  logic [11:0]  line_bytes_o;
  logic         bpp16_o;
  logic         pipe_busy_o;
  logic         blit_busy_o;
  logic         pending_o;
  // Scoreboard counters
  int           fails;
  int           samples_checked;
  logic [31:0]  rdat;
  logic [31:0]  bval;

  blvm_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
                   .pipe_done_i(pipe_done_i), .mem_done_i(mem_done_i), .start_o(start_o), .op_o(op_o),
                   .line_bytes_o(line_bytes_o), .bpp16_o(bpp16_o), .pipe_busy_o(pipe_busy_o),
                   .blit_busy_o(blit_busy_o), .pending_o(pending_o));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // Verdict and end of run; also reached when a wait runs out
  task print_verdict();
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One comparison, counted
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // Watched outputs, picked by number so the bounded wait needs no reference argument
  localparam int W_ACK   = 0;
  localparam int W_START = 1;
  localparam int W_PIPE  = 2;
  localparam int W_BLIT  = 3;

  function automatic logic watch(input int which);
    case (which)
      W_ACK:   watch = wb_ack_o;
      W_START: watch = start_o;
      W_PIPE:  watch = pipe_busy_o;
      default: watch = blit_busy_o;
    endcase
  endfunction

  // Bounded wait on a sampled level; a hang counts as a mismatch
  task automatic wait_lvl(input int which, input logic v, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (watch(which) !== v && n < 40);
    if (watch(which) !== v) begin
      check(nm, {31'b0, v}, {31'b0, watch(which)});
      print_verdict();
    end
  endtask

  // Classic Wishbone cycle: held until ack is sampled, then released for a cycle
  task wb_xfer(input logic we, input logic [15:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    wait_lvl(W_ACK, 1'b1, "wb ack");
    rdat = wb_dat_o;
    wb_i <= '0;
  endtask

  // Read and compare a register
  task rd_chk(input string nm, input logic [15:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF);
    check(nm, exp, rdat);
  endtask

  // Let the engine finish: pipeline first, then memory requests
  task finish_op();
    pipe_done_i <= 1'b1;
    wait_lvl(W_PIPE, 1'b0, "pipe busy fall");
    check("busy held past pipe", 32'h1, {31'b0, blit_busy_o});
    pipe_done_i <= 1'b0;
    mem_done_i  <= 1'b1;
    wait_lvl(W_BLIT, 1'b0, "blit busy fall");
    mem_done_i  <= 1'b0;
  endtask

  // Expected operand decodes {kind, ones, buf}; pattern color enables per mode
  // Code 110 stands for the undefined destination codes, which act as none
  logic [2:0] dsel[6] = '{3'd0, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6};
  logic [3:0] dexp[6] = '{4'b0010, 4'b0100, 4'b0101, 4'b1000, 4'b1001, 4'b0010};
  logic [3:0] sexp[4] = '{4'b0010, 4'b1000, 4'b0100, 4'b0101};
  logic [3:0] pce[4]  = '{4'b0001, 4'b0011, 4'b1111, 4'b0000};

  initial begin
    fails = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped address reads zero
    rd_chk("raster rst", `BLVM_RASTER_OFS, 32'h0000_0000);
    rd_chk("vector rst", `BLVM_VECTOR_OFS, 32'h0000_0000);
    rd_chk("blit rst", `BLVM_BLIT_OFS, 32'h0000_0000);
    rd_chk("status rst", `BLVM_STATUS_OFS, 32'h0000_0000);
    rd_chk("unmapped", 16'h8210, 32'h0000_0000);
    check("line rst", 32'h0000_0400, {20'b0, line_bytes_o});
    // Vector register: reserved bits dropped, byte lanes honoured, no launch
    wb_xfer(1'b1, `BLVM_VECTOR_OFS, 32'hFFFF_FFFF, 4'hF);
    rd_chk("vector all", `BLVM_VECTOR_OFS, 32'h0000_000F);
    wb_xfer(1'b1, `BLVM_VECTOR_OFS, 32'h0000_0006, 4'h1);
    wb_xfer(1'b1, `BLVM_VECTOR_OFS, 32'h0000_0000, 4'hE);
    rd_chk("vector sel", `BLVM_VECTOR_OFS, 32'h0000_0006);
    check("no launch", 32'h0, {31'b0, pending_o});
    // Frame format bits
    wb_xfer(1'b1, `BLVM_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
    rd_chk("status fmt", `BLVM_STATUS_OFS, 32'h0000_0300);
    check("line wide", 32'h0000_0800, {20'b0, line_bytes_o});
    check("bpp16", 32'h1, {31'b0, bpp16_o});
    // Every pattern mode through a raster launch
    for (int p = 0; p < 4; p++) begin
      wb_xfer(1'b1, `BLVM_RASTER_OFS, {22'b0, p[1:0], 8'hA5 ^ p[7:0]}, 4'hF);
      wait_lvl(W_START, 1'b1, "raster start");
      check("pat", {30'b0, p[1:0]}, {30'b0, op_o.pat});
      check("pat colors", {28'b0, pce[p]}, {28'b0, op_o.pat_color_en});
      check("pat data", {31'b0, p == 3}, {31'b0, op_o.pat_from_data});
      check("rop", {24'b0, 8'hA5 ^ p[7:0]}, {24'b0, op_o.raster_op_code});
      check("vec bits", 32'h6, {28'b0, op_o.fetch_fb_dst, op_o.minor_pos, op_o.major_pos, op_o.y_major});
      check("raster kind", 32'h0, {31'b0, op_o.is_blit});
      finish_op();
    end
    // Every defined destination code plus undefined 110, every source and source format code through a blit launch
    for (int i = 0; i < 6; i++) begin
      bval = {23'b0, i[0], i[1:0], 1'b0, dsel[i][2:0], i[1:0]};
      wb_xfer(1'b1, `BLVM_BLIT_OFS, bval, 4'hF);
      wait_lvl(W_START, 1'b1, "blit start");
      check("blit kind", 32'h1, {31'b0, op_o.is_blit});
      check("dst", {28'b0, dexp[i]}, {28'b0, op_o.dst_kind, op_o.dst_ones, op_o.dst_buf});
      check("src", {28'b0, sexp[i % 4]}, {28'b0, op_o.src_kind, op_o.src_ones, op_o.src_buf});
      check("sfmt", {30'b0, i[1:0]}, {30'b0, op_o.sfmt});
      check("expand", {31'b0, i % 4 == 1 || i % 4 == 3}, {31'b0, op_o.color_expand});
      check("glyph adv", {31'b0, i % 4 == 3}, {31'b0, op_o.glyph_x_adv});
      check("y rev", {31'b0, i[0]}, {31'b0, op_o.y_reverse});
      finish_op();
      rd_chk("blit back", `BLVM_BLIT_OFS, bval);
    end
    // Launch while busy is held pending, then runs after the first completes
    wb_xfer(1'b1, `BLVM_BLIT_OFS, 32'h0000_0002, 4'hF);
    wait_lvl(W_START, 1'b1, "busy start");
    rd_chk("status busy", `BLVM_STATUS_OFS, 32'h0000_0303);
    wb_xfer(1'b1, `BLVM_RASTER_OFS, 32'h0000_0133, 4'hF);
    rd_chk("status pend", `BLVM_STATUS_OFS, 32'h0000_0307);
    check("pending", 32'h1, {31'b0, pending_o});
    finish_op();
    wait_lvl(W_START, 1'b1, "pend start");
    check("pend rop", 32'h0000_0033, {24'b0, op_o.raster_op_code});
    check("pend kind", 32'h0, {31'b0, op_o.is_blit});
    check("pend clear", 32'h0, {31'b0, pending_o});
    finish_op();
    rd_chk("status idle", `BLVM_STATUS_OFS, 32'h0000_0300);
    print_verdict();
  end

endmodule // test_blit_vector_mode_control
